/* File: core/nbac_top.sv */
// Block access control with APB view of the protection settings
//
// What this block does
// - Memory is 64 blocks of sixteen bytes
// - Blocks 0-59 user, 60-63 system area
// - RF access decided per block, three sources
// - Mode 0: lock denies, auth restores read-only bit
// - Mode 1: lock plus read-only reads before auth
// - Access mode bit resets to zero
// - RF read-only bits at 0x3F0, grouped layout
// - Lock bits same layout at 0x3F8
// - Serial access: read-only bit one means read-only
// - Serial read-only bits same layout at 0x3F4
// - All protection bits reset to zero
// - Hardware config word at 0x3EE, fixed fields
`timescale 1ns/1ps
module nbac_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_valid,
	input wire logic cmd_serial,
	input wire logic cmd_write,
	input wire logic [9:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic pw_authenticated,
	output logic rsp_valid,
	output logic rsp_error,
	output logic [7:0] rsp_rdata,
	output logic access_mode_bit,
	output logic wait_extension_enable,
	output logic type_b_speed_select,
	output logic identifier_source_select,
	output logic rf_speed_limit,
	output logic [2:0] protocol_select,
	output logic [6:0] slave_address_field
);
	import nbac_pkg::*;

	// Bits that hold state in each config byte; the rest read zero
	function automatic logic [7:0] cfg_keep(input int k);
		if (k == NBAC_CFG_HW + 1) begin
			cfg_keep = NBAC_HW_HI_KEEP;
		end else if (k == NBAC_CFG_RF + 3 || k == NBAC_CFG_SER + 3 ||
			k == NBAC_CFG_LOCK + 3) begin
			cfg_keep = NBAC_MASK_TOP_KEEP;
		end else begin
			cfg_keep = 8'hFF;
		end
	endfunction

	// Reset value of each config byte
	function automatic logic [7:0] cfg_reset(input int k);
		if (k == NBAC_CFG_HW) begin
			cfg_reset = NBAC_HW_LO_RESET;
		end else if (k == NBAC_CFG_HW + 1) begin
			cfg_reset = NBAC_HW_HI_RESET;
		end else begin
			cfg_reset = NBAC_MASK_RESET;
		end
	endfunction

	// Storage: plain bytes for the array, flops for protection bytes
	logic [7:0] mem [0:NBAC_MEM_BYTES-1];
	logic [7:0] cfg_q [0:NBAC_CFG_BYTES-1];
	logic [7:0] cfg_d [0:NBAC_CFG_BYTES-1];
	logic [31:0] prdata_q;
	logic rsp_valid_q;
	logic rsp_error_q;
	logic [7:0] rsp_rdata_q;

	// Assembled register views
	wire logic [15:0] hw_word = {cfg_q[NBAC_CFG_HW + 1], cfg_q[NBAC_CFG_HW]};
	wire logic [31:0] rf_ro = {cfg_q[NBAC_CFG_RF + 3], cfg_q[NBAC_CFG_RF + 2],
		cfg_q[NBAC_CFG_RF + 1], cfg_q[NBAC_CFG_RF]};
	wire logic [31:0] ser_ro = {cfg_q[NBAC_CFG_SER + 3],
		cfg_q[NBAC_CFG_SER + 2], cfg_q[NBAC_CFG_SER + 1], cfg_q[NBAC_CFG_SER]};
	wire logic [31:0] lock_m = {cfg_q[NBAC_CFG_LOCK + 3],
		cfg_q[NBAC_CFG_LOCK + 2], cfg_q[NBAC_CFG_LOCK + 1],
		cfg_q[NBAC_CFG_LOCK]};

	// Hardware configuration fields steer the rest of the tag
	assign access_mode_bit = hw_word[NBAC_MODE_POS];
	assign wait_extension_enable = hw_word[NBAC_WTX_POS];
	assign type_b_speed_select = hw_word[NBAC_TYPB_POS];
	assign identifier_source_select = hw_word[NBAC_IDSRC_POS];
	assign rf_speed_limit = hw_word[NBAC_RFSPD_POS];
	assign protocol_select = hw_word[NBAC_PROTO_POS +: 3];
	assign slave_address_field = hw_word[NBAC_SLAVE_POS +: 7];

	// APB address decode
	wire logic sel_hw = (paddr == NBAC_ADDR_HW_CFG);
	wire logic sel_rf = (paddr == NBAC_ADDR_RF_RO);
	wire logic sel_ser = (paddr == NBAC_ADDR_SER_RO);
	wire logic sel_lock = (paddr == NBAC_ADDR_LOCK);
	wire logic apb_hit = sel_hw | sel_rf | sel_ser | sel_lock;
	wire logic apb_setup = psel & ~penable;
	wire logic apb_wr = psel & penable & pwrite & apb_hit;

	// Zero wait states; unmapped words answer with an error
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~apb_hit;
	assign prdata = prdata_q;

	// Read data is captured in the setup phase so it leaves a flop
	wire logic [31:0] apb_rd = sel_hw ? {16'h0000, hw_word} :
		sel_rf ? rf_ro : sel_ser ? ser_ro : sel_lock ? lock_m : 32'h00000000;

	// Permission for the command in flight
	logic can_read;
	logic can_write;
	nbac_perm u_perm (
		.block(cmd_addr[9:4]),
		.serial_mode(cmd_serial),
		.authenticated(pw_authenticated),
		.access_mode_bit(access_mode_bit),
		.rf_read_only_bits(rf_ro),
		.serial_read_only_bits(ser_ro),
		.password_lock_bits(lock_m),
		.can_read(can_read),
		.can_write(can_write)
	);

	// Command decode
	wire logic cfg_hit = (cmd_addr >= NBAC_CFG_BASE) &&
		(cmd_addr <= NBAC_CFG_LAST);
	wire logic [3:0] cfg_idx = 4'(cmd_addr - NBAC_CFG_BASE);
	wire logic cmd_ok = cmd_write ? can_write : can_read;
	wire logic cmd_wr = cmd_valid & cmd_write & can_write;
	wire logic [7:0] cmd_rd = cfg_hit ? cfg_q[cfg_idx] : mem[cmd_addr];

	// Next config bytes: bus writes first, a granted command byte wins
	always_comb begin
		for (int k = 0; k < NBAC_CFG_BYTES; k++) begin
			cfg_d[k] = cfg_q[k];
			if (k < NBAC_CFG_RF) begin
				if (apb_wr && sel_hw) begin
					cfg_d[k] = pwdata[(k - NBAC_CFG_HW) * 8 +: 8];
				end
			end else if (k < NBAC_CFG_SER) begin
				if (apb_wr && sel_rf) begin
					cfg_d[k] = pwdata[(k - NBAC_CFG_RF) * 8 +: 8];
				end
			end else if (k < NBAC_CFG_LOCK) begin
				if (apb_wr && sel_ser) begin
					cfg_d[k] = pwdata[(k - NBAC_CFG_SER) * 8 +: 8];
				end
			end else begin
				if (apb_wr && sel_lock) begin
					cfg_d[k] = pwdata[(k - NBAC_CFG_LOCK) * 8 +: 8];
				end
			end
			if (cmd_wr && cfg_hit && cfg_idx == 4'(k)) begin
				cfg_d[k] = cmd_wdata;
			end
			// Reserved bits are not stored, so they always read zero
			cfg_d[k] = cfg_d[k] & cfg_keep(k);
		end
	end

	// Protection bytes with defined reset values
	// Reset test stays outermost so the flops map onto async-reset cells
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < NBAC_CFG_BYTES; k++) begin
				cfg_q[k] <= cfg_reset(k);
			end
		end else begin
			for (int k = 0; k < NBAC_CFG_BYTES; k++) begin
				cfg_q[k] <= cfg_d[k];
			end
		end
	end

	// Array body has no reset, like the cells it stands for
	always_ff @(posedge pclk) begin
		if (cmd_wr && !cfg_hit) begin
			mem[cmd_addr] <= cmd_wdata;
		end
	end

	// APB read capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (apb_setup) begin
			prdata_q <= apb_rd;
		end
	end

	// Command answer one cycle later; denied reads return zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_valid_q <= 1'b0;
			rsp_error_q <= 1'b0;
			rsp_rdata_q <= 8'h00;
		end else begin
			rsp_valid_q <= cmd_valid;
			rsp_error_q <= cmd_valid & ~cmd_ok;
			if (cmd_valid && !cmd_write && can_read) begin
				rsp_rdata_q <= cmd_rd;
			end else begin
				rsp_rdata_q <= 8'h00;
			end
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp_error = rsp_error_q;
	assign rsp_rdata = rsp_rdata_q;
endmodule

/* File: inc/nbac_pkg.sv */
// Constants shared by the block access control logic and its decoder
package nbac_pkg;
	// Memory organisation
	localparam int NBAC_BLOCKS = 64;
	localparam int NBAC_BLOCK_BYTES = 16;
	localparam int NBAC_MEM_BYTES = NBAC_BLOCKS * NBAC_BLOCK_BYTES;
	localparam logic [5:0] NBAC_USER_LAST_BLOCK = 6'h3B;
	localparam logic [9:0] NBAC_SYS_BASE = 10'h3C0;

	// Register indexes; the bus address is four times the index
	localparam int NBAC_IDX_HW_CFG = 32'h000003EE;
	localparam int NBAC_IDX_RF_RO = 32'h000003F0;
	localparam int NBAC_IDX_SER_RO = 32'h000003F4;
	localparam int NBAC_IDX_LOCK = 32'h000003F8;
	localparam logic [11:0] NBAC_ADDR_HW_CFG = 12'(NBAC_IDX_HW_CFG * 4);
	localparam logic [11:0] NBAC_ADDR_RF_RO = 12'(NBAC_IDX_RF_RO * 4);
	localparam logic [11:0] NBAC_ADDR_SER_RO = 12'(NBAC_IDX_SER_RO * 4);
	localparam logic [11:0] NBAC_ADDR_LOCK = 12'(NBAC_IDX_LOCK * 4);

	// Configuration bytes held in flops: byte 0 sits at memory 0x3EE
	localparam logic [9:0] NBAC_CFG_BASE = 10'h3EE;
	localparam logic [9:0] NBAC_CFG_LAST = 10'h3FB;
	localparam int NBAC_CFG_BYTES = 14;
	localparam int NBAC_CFG_HW = 0;
	localparam int NBAC_CFG_RF = 2;
	localparam int NBAC_CFG_SER = 6;
	localparam int NBAC_CFG_LOCK = 10;

	// Hardware configuration word fields (low byte is 0x3EE)
	localparam int NBAC_MODE_POS = 7;
	localparam int NBAC_WTX_POS = 6;
	localparam int NBAC_TYPB_POS = 5;
	localparam int NBAC_IDSRC_POS = 4;
	localparam int NBAC_RFSPD_POS = 3;
	localparam int NBAC_PROTO_POS = 0;
	localparam int NBAC_SLAVE_POS = 8;
	localparam logic [7:0] NBAC_HW_LO_RESET = 8'h0F;
	localparam logic [7:0] NBAC_HW_HI_RESET = 8'h54;
	localparam logic [7:0] NBAC_HW_HI_KEEP = 8'h7F;
	localparam logic [7:0] NBAC_MASK_TOP_KEEP = 8'h07;
	localparam logic [7:0] NBAC_MASK_RESET = 8'h00;

	// Block to permission bit grouping
	localparam logic [5:0] NBAC_GROUP_FIRST = 6'h04;
	localparam logic [5:0] NBAC_SINGLE_BLOCK = 6'h30;
	localparam logic [4:0] NBAC_SINGLE_BIT = 5'h0F;
	localparam logic [5:0] NBAC_TAIL_FIRST = 6'h31;
	localparam logic [4:0] NBAC_TAIL_BIT = 5'h10;
endpackage

/* File: core/nbac_perm.sv */
// Permission decoder: one block's read and write rights
`timescale 1ns/1ps
module nbac_perm (
	input wire logic [5:0] block,
	input wire logic serial_mode,
	input wire logic authenticated,
	input wire logic access_mode_bit,
	input wire logic [31:0] rf_read_only_bits,
	input wire logic [31:0] serial_read_only_bits,
	input wire logic [31:0] password_lock_bits,
	output logic can_read,
	output logic can_write
);
	import nbac_pkg::*;

	// Block number to mask bit; blocks 4-47 share one bit per four
	function automatic logic [4:0] perm_bit(input logic [5:0] b);
		logic [5:0] g;
		g = b - NBAC_GROUP_FIRST;
		if (b < NBAC_GROUP_FIRST) begin
			perm_bit = b[4:0];
		end else if (b < NBAC_SINGLE_BLOCK) begin
			perm_bit = 5'(NBAC_GROUP_FIRST) + {1'b0, g[5:2]};
		end else if (b == NBAC_SINGLE_BLOCK) begin
			perm_bit = NBAC_SINGLE_BIT;
		end else begin
			perm_bit = NBAC_TAIL_BIT + 5'(b - NBAC_TAIL_FIRST);
		end
	endfunction

	logic [4:0] bit_idx;
	logic user_blk;
	logic ro;
	logic lock;
	logic sro;

	// Mask bits for this block; system blocks carry no bits
	assign bit_idx = perm_bit(block);
	assign user_blk = (block <= NBAC_USER_LAST_BLOCK);
	assign ro = user_blk & rf_read_only_bits[bit_idx];
	assign lock = user_blk & password_lock_bits[bit_idx];
	assign sro = user_blk & serial_read_only_bits[bit_idx];

	// Serial side only looks at its own read-only bit
	// RF side: lock denies all until authentication, except reads of read-only blocks in mode 1
	assign can_read = serial_mode | ~lock | authenticated |
		(access_mode_bit & ro);
	assign can_write = serial_mode ? ~sro :
		(lock ? (authenticated & (~ro | access_mode_bit)) : ~ro);
endmodule

/* File: bench/nbac_cmd_host.sv */
// Command source model standing in for the reader or host side
`timescale 1ns/1ps
module nbac_cmd_host (
	input wire logic pclk,
	output logic cmd_valid,
	output logic cmd_serial,
	output logic cmd_write,
	output logic [9:0] cmd_addr,
	output logic [7:0] cmd_wdata,
	input wire logic rsp_valid,
	input wire logic rsp_error,
	input wire logic [7:0] rsp_rdata
);
	// Idle from time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_serial = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 10'h000;
		cmd_wdata = 8'h00;
	end

	// One byte a command; on release address and data flip so stale values never match
	task automatic cmd(input logic s, input logic w, input logic [9:0] a,
		input logic [7:0] d, output logic err, output logic [7:0] q);
		@(posedge pclk);
		cmd_valid <= 1'b1;
		cmd_serial <= s;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge pclk);
		cmd_valid <= 1'b0;
		cmd_addr <= ~a;
		cmd_wdata <= ~d;
		#1;
		err = rsp_valid ? rsp_error : 1'bx; // Missing answer reads unknown
		q = rsp_rdata;
	endtask
endmodule

/* File: bench/nbac_chk_sva.sv */
// Port assertions for the block access control
`timescale 1ns/1ps
module nbac_chk
	import nbac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cmd_valid,
	input wire logic cmd_serial,
	input wire logic cmd_write,
	input wire logic [9:0] cmd_addr,
	input wire logic pw_authenticated,
	input wire logic rsp_valid,
	input wire logic rsp_error,
	input wire logic [7:0] rsp_rdata,
	input wire logic access_mode_bit
);
	import nbac_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Only four words answer on the bus
	wire mapped = paddr == NBAC_ADDR_HW_CFG || paddr == NBAC_ADDR_RF_RO ||
		paddr == NBAC_ADDR_SER_RO || paddr == NBAC_ADDR_LOCK;
	wire apb_access = psel && penable;
	sequence s_rf_rd;
		cmd_valid && !cmd_serial && !cmd_write;
	endsequence
	property p_rsp_lat; cmd_valid |=> rsp_valid; endproperty
	property p_rsp_idle; !cmd_valid |=> !rsp_valid; endproperty
	property p_deny; rsp_valid && rsp_error |-> rsp_rdata == 8'h00;
	endproperty
	property p_ser_rd; cmd_valid && cmd_serial && !cmd_write |=> !rsp_error;
	endproperty
	property p_sys; cmd_valid && cmd_addr[9:6] == 4'hF |=> !rsp_error;
	endproperty
	property p_auth_rd; s_rf_rd ##0 pw_authenticated |=> !rsp_error;
	endproperty
	property p_ready; apb_access |-> pready && pslverr == !mapped;
	endproperty
	property p_hold; !(apb_access && pwrite) && !cmd_valid |=>
		$stable(access_mode_bit);
	endproperty
	// Writes never echo data, and an error never comes alone
	property p_wr_zero; cmd_valid && cmd_write |=> rsp_rdata == 8'h00;
	endproperty
	property p_err_ok; !rsp_valid |-> !rsp_error; endproperty
	a_rsp_lat: assert property (p_rsp_lat) else $error("no answer");
	a_rsp_idle: assert property (p_rsp_idle) else $error("stray answer");
	a_deny: assert property (p_deny) else $error("denied data");
	a_ser_rd: assert property (p_ser_rd) else $error("serial read");
	a_sys: assert property (p_sys) else $error("system block");
	a_auth_rd: assert property (p_auth_rd) else $error("auth read");
	a_ready: assert property (p_ready) else $error("bus answer");
	a_hold: assert property (p_hold) else $error("mode moved");
	a_wr_zero: assert property (p_wr_zero) else $error("wr data");
	a_err_ok: assert property (p_err_ok) else $error("lone error");
endmodule
bind nbac_top nbac_chk i_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pready(pready),
	.pslverr(pslverr),
	.cmd_valid(cmd_valid),
	.cmd_serial(cmd_serial),
	.cmd_write(cmd_write),
	.cmd_addr(cmd_addr),
	.pw_authenticated(pw_authenticated),
	.rsp_valid(rsp_valid),
	.rsp_error(rsp_error),
	.rsp_rdata(rsp_rdata),
	.access_mode_bit(access_mode_bit)
);

/* File: bench/tb_top.sv */
// Self-checking bench for the block access control
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	import nbac_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pw_auth;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic cmd_valid, cmd_serial, cmd_write, rsp_valid, rsp_error;
	logic [9:0] cmd_addr;
	logic [7:0] cmd_wdata, rsp_rdata, rd, last;
	logic access_mode_bit, e, rok, wok;
	logic [2:0] protocol_select;
	logic [6:0] slave_address_field;
	logic wait_extension_enable, type_b_speed_select;
	logic identifier_source_select, rf_speed_limit;
	logic [14:0] hw_fields;
	logic [11:0] ma [3];
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	nbac_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cmd_valid, .cmd_serial,
		.cmd_write, .cmd_addr, .cmd_wdata, .pw_authenticated(pw_auth),
		.rsp_valid, .rsp_error, .rsp_rdata, .access_mode_bit,
		.wait_extension_enable, .type_b_speed_select,
		.identifier_source_select, .rf_speed_limit, .protocol_select,
		.slave_address_field);
	// All configuration outputs in one word, access mode on top
	assign hw_fields = {access_mode_bit, wait_extension_enable,
		type_b_speed_select, identifier_source_select, rf_speed_limit,
		protocol_select, slave_address_field};
	nbac_cmd_host i_host (.pclk, .cmd_valid, .cmd_serial, .cmd_write,
		.cmd_addr, .cmd_wdata, .rsp_valid, .rsp_error, .rsp_rdata);
	// Clock, 20 ns period
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			report_and_stop;
		end
	end
	// One APB transfer; result left in q and e
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pw_auth = 1'b0;
		ma = '{NBAC_ADDR_RF_RO, NBAC_ADDR_SER_RO, NBAC_ADDR_LOCK};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, NBAC_ADDR_HW_CFG, 32'h0);
		`CHK(q, 32'h0000540F)
		`CHK(hw_fields, 15'h07D4)
		// Every field toggled; reserved bits kept at zero
		apb(1'b1, NBAC_ADDR_HW_CFG, 32'h00002BF0);
		apb(1'b0, NBAC_ADDR_HW_CFG, 32'h0);
		`CHK({q, hw_fields}, {32'h00002BF0, 15'h782B})
		i_host.cmd(1'b0, 1'b0, 10'h3EF, 8'h00, e, rd);
		`CHK({e, rd}, 9'h02B)
		apb(1'b1, 12'h004, 32'h1);
		`CHK(e, 1'b1)
		apb(1'b0, 12'h004, 32'h0);
		`CHK({e, q}, {1'b1, 32'h0})
		$display("reset test done");
		// Reserved top bits never stick
		foreach (ma[i]) begin
			apb(1'b0, ma[i], 32'h0);
			`CHK(q, 32'h0)
			apb(1'b1, ma[i], 32'hFFFFFFFF);
			apb(1'b0, ma[i], 32'h0);
			`CHK(q, 32'h07FFFFFF)
		end
		i_host.cmd(1'b0, 1'b1, 10'h3C0, 8'h5A, e, rd);
		`CHK(e, 1'b0)
		$display("mask test done");
		// Block 48 alone on bit 15, block 47 shares bit 14, 59 on bit 26
		apb(1'b1, NBAC_ADDR_SER_RO, 32'h04008000);
		i_host.cmd(1'b1, 1'b1, 10'h300, 8'h11, e, rd);
		`CHK(e, 1'b1)
		i_host.cmd(1'b1, 1'b1, 10'h3B0, 8'h33, e, rd);
		`CHK(e, 1'b1)
		i_host.cmd(1'b1, 1'b1, 10'h2F0, 8'h22, e, rd);
		`CHK(e, 1'b0)
		i_host.cmd(1'b1, 1'b0, 10'h2F0, 8'h00, e, rd);
		`CHK({e, rd}, 9'h022)
		$display("serial test done");
		// Block 5 on bit 4: every mode, lock, read-only and auth case
		for (int m = 0; m < 2; m++) begin
			for (int c = 0; c < 8; c++) begin
				apb(1'b1, NBAC_ADDR_HW_CFG, {16'h0, 8'h54, m[0], 7'h0F});
				apb(1'b1, NBAC_ADDR_RF_RO, {27'h0, c[0], 4'h0});
				apb(1'b1, NBAC_ADDR_LOCK, {27'h0, c[1], 4'h0});
				pw_auth <= c[2];
				rok = !c[1] || c[2] || (m[0] && c[0]);
				wok = (!c[0] && (!c[1] || c[2])) || (m[0] && &c[2:0]);
				i_host.cmd(1'b0, 1'b1, 10'h05A, 8'(c + 8 * m), e, rd);
				`CHK({access_mode_bit, e}, {m[0], !wok})
				if (wok)
					last = 8'(c + 8 * m);
				i_host.cmd(1'b0, 1'b0, 10'h05A, 8'h00, e, rd);
				`CHK({e, rd}, {!rok, rok ? last : 8'h00})
			end
		end
		$display("permission test done");
		report_and_stop;
	end
endmodule
